//--- pkg/rms_power_pkg.sv
package rms_power_pkg;
    localparam int CLK_HZ        = 100_000_000;
    localparam int SAMPLE_HZ     = 8_000;
    localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
    localparam int RMS_SETTLE_MS = 580;
    localparam int PWR_SETTLE_MS = 650;
    localparam int PWR_STRONG_MS = 1300;

    localparam logic [15:0] ADDR_POWER_A = 16'hE518;
    localparam logic [15:0] ADDR_POWER_B = 16'hE519;
    localparam logic [15:0] ADDR_POWER_C = 16'hE51A;
    localparam logic [15:0] ADDR_CONFIG  = 16'hE618;
    localparam logic [15:0] ADDR_ACCUMULATION_MODE_CONTROL = 16'hE701;

    localparam logic [15:0] CONFIG_RESET  = 16'h0000;
    localparam logic [7:0]  ACCUMULATION_MODE_CONTROL_RESET = 8'h00;
    localparam int FILTER_STRENGTH_BIT = 5;
    localparam int CONNECTION_SELECT_LSB          = 4;
    localparam logic [1:0] CONNECTION_SELECT_WYE    = 2'b00;
    localparam logic [1:0] CONNECTION_SELECT_DELTA3 = 2'b01;
    localparam logic [1:0] CONNECTION_SELECT_DELTA4 = 2'b11;

    localparam int RMS_OS_SHIFT      = 7;
    localparam int GAIN_SHIFT        = 23;
    localparam int POWER_NORM_SHIFT  = 19;
    localparam int POWER_STORE_SHIFT = 4;
    localparam int RMS_LPF_SHIFT     = 10;
    localparam int POWER_LPF_SHIFT   = 10;
    localparam int SQRT_STEPS        = 24;
    localparam logic [23:0] RMS_MAX  = 24'h7F_FFFF;

    localparam int NUM_RMS_CH = 14;
    localparam int CH_VA  = 0;
    localparam int CH_VB  = 1;
    localparam int CH_VC  = 2;
    localparam int CH_VN  = 3;
    localparam int CH_FVA = 4;
    localparam int CH_FVB = 5;
    localparam int CH_FVC = 6;
    localparam int CH_IA  = 7;
    localparam int CH_FIA = 11;

    typedef struct packed {
        logic [3:0][23:0] volt;
        logic [3:0][23:0] curr;
        logic [2:0][23:0] fund_volt;
        logic [2:0][23:0] fund_curr;
    } samples_t;

    typedef logic [NUM_RMS_CH-1:0][23:0] rms_offsets_t;
    typedef logic [NUM_RMS_CH-1:0][31:0] rms_words_t;
    typedef logic [2:0][23:0]            phase_words_t;

    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_SQUARE = 3'b001,
        S_SQRT   = 3'b010,
        S_STORE  = 3'b011,
        S_POWER  = 3'b100
    } engine_state_t;
endpackage

//--- rtl/rms_power_datapath.sv
// What this block does
// (R1) Current rms offset, signed 24-bit, times 128 added to mean square before root.
// (R2) Voltage rms offset, signed 24-bit, times 128 added to mean square before root.
// (R3) Offset readback: sign extended to 28 bits, four zero bits on top.
// (R4) Voltage and fundamental voltage rms for all channels, signed 24-bit, 8 kHz.
// (R5) Full-scale code near 5,320,000 gives rms 3,761,808 at any line frequency.
// (R6) Voltage rms settles from zero to input within 580 ms.
// (R7) Voltage rms bandwidth is 3.3 kHz.
// (R8) Rms result words carry zero in the top eight bits.
// (R9) Host reads rms once per line cycle over one second and averages.
// (R10) Host calibrates rms offsets at low level, not at zero input.
// (R11) Three-wire delta forces all phase B powers to zero.
// (R12) Three-wire delta: phase B voltage is raw A minus raw C.
// (R13) Phase B gain and rms offsets still act on synthesised phase B.
// (R14) Four-wire delta: phase B voltage is the negated raw A sample.
// (R15) Total active power includes harmonics; fundamental power is separate.
// (R16) Per phase, current times voltage, low-pass filtered to average power.
// (R17) Filter strength bit selects 650 ms or 1300 ms power filter.
// (R18) Instantaneous power per phase in three 24-bit registers E518 to E51A.
// (R19) Full-scale in-phase power is 26,991,271; stored value is that over 16.
// (R20) Power registers readable over the register port.
// (R21) Current rms results refresh at 8 kHz.
// (R22) All channels finish updating within one 8 kHz sample period.
// (R23) Negative compensated square clamps to zero before the root.
module rms_power_datapath #(
    parameter int SAMPLE_CYCLES = rms_power_pkg::SAMPLE_CYCLES
) (
    input  wire logic                      clk_in,
    input  wire logic                      reset_n_in,
    input  wire rms_power_pkg::samples_t   samples_in,
    input  wire rms_power_pkg::rms_offsets_t rms_offset_in,
    input  wire rms_power_pkg::phase_words_t voltage_gain_in,
    input  wire logic [15:0]               reg_addr_in,
    input  wire logic                      reg_write_in,
    input  wire logic                      reg_read_in,
    input  wire logic [31:0]               reg_wdata_in,
    input  wire logic [3:0]                offset_sel_in,
    output logic [31:0]                    reg_rdata_out,
    output logic                           reg_rdata_valid_out,
    output logic [31:0]                    offset_word_out,
    output rms_power_pkg::rms_words_t      rms_word_out,
    output rms_power_pkg::phase_words_t    instant_power_out,
    output logic                           rms_update_out
);
    localparam int CNT_W = $clog2(SAMPLE_CYCLES);

    function automatic logic [23:0] apply_gain(input logic [23:0] x, input logic [23:0] g);
        logic signed [47:0] m;
        m = $signed(x) * $signed(g);
        return x + m[rms_power_pkg::GAIN_SHIFT +: 24];
    endfunction

    function automatic logic signed [47:0] sx48(input logic [23:0] x);
        return {{24{x[23]}}, x};
    endfunction

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    // Sample-rate divider
    logic [CNT_W-1:0] tick_cnt;
    logic [CNT_W-1:0] next_tick_cnt;
    logic             tick;

    assign tick = (tick_cnt == CNT_W'(SAMPLE_CYCLES - 1));

    always_comb
    begin
        next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
            tick_cnt <= '0;
        else
            tick_cnt <= next_tick_cnt;
    end

    // Register port
    logic [15:0] metering_configuration;
    logic [7:0]  accumulation_mode_control;
    logic [15:0] next_config;
    logic [7:0]  next_accumulation_mode_control;
    logic [31:0] next_rdata;
    logic [31:0] next_offset_word;
    logic [1:0]  connection_select;
    logic        power_filter_strength;

    assign connection_select     = accumulation_mode_control[rms_power_pkg::CONNECTION_SELECT_LSB +: 2];
    assign power_filter_strength = metering_configuration[rms_power_pkg::FILTER_STRENGTH_BIT];

    always_comb
    begin
        next_config  = metering_configuration;
        next_accumulation_mode_control = accumulation_mode_control;
        if (reg_write_in && reg_addr_in == rms_power_pkg::ADDR_CONFIG)
            next_config = reg_wdata_in[15:0];
        if (reg_write_in && reg_addr_in == rms_power_pkg::ADDR_ACCUMULATION_MODE_CONTROL)
            next_accumulation_mode_control = reg_wdata_in[7:0];
        case (reg_addr_in)
            rms_power_pkg::ADDR_POWER_A: next_rdata = {8'h00, instant_power_out[0]}; // [R18] [R20]
            rms_power_pkg::ADDR_POWER_B: next_rdata = {8'h00, instant_power_out[1]}; // [R18] [R20]
            rms_power_pkg::ADDR_POWER_C: next_rdata = {8'h00, instant_power_out[2]}; // [R18] [R20]
            rms_power_pkg::ADDR_CONFIG:  next_rdata = {16'h0000, metering_configuration};
            rms_power_pkg::ADDR_ACCUMULATION_MODE_CONTROL: next_rdata = {24'h00_0000, accumulation_mode_control};
            default:                     next_rdata = 32'h0000_0000;
        endcase
        if (offset_sel_in < 4'(rms_power_pkg::NUM_RMS_CH))
            next_offset_word = {4'h0, {4{rms_offset_in[offset_sel_in][23]}},
                                rms_offset_in[offset_sel_in]}; // [R3]
        else
            next_offset_word = 32'h0000_0000;
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            metering_configuration    <= rms_power_pkg::CONFIG_RESET;
            accumulation_mode_control <= rms_power_pkg::ACCUMULATION_MODE_CONTROL_RESET;
            reg_rdata_out             <= 32'h0000_0000;
            reg_rdata_valid_out       <= 1'b0;
            offset_word_out           <= 32'h0000_0000;
        end
        else
        begin
            metering_configuration    <= next_config;
            accumulation_mode_control <= next_accumulation_mode_control;
            reg_rdata_out             <= reg_read_in ? next_rdata : reg_rdata_out;
            reg_rdata_valid_out       <= reg_read_in;
            offset_word_out           <= next_offset_word;
        end
    end

    a_config_read: assert property ((reg_read_in && reg_addr_in == rms_power_pkg::ADDR_CONFIG) // [R17]
        |=> reg_rdata_out == {16'h0000, $past(metering_configuration)})
        else $error("config readback wrong");
    a_power_read: assert property ((reg_read_in && reg_addr_in == rms_power_pkg::ADDR_POWER_B) // [R20]
        |=> reg_rdata_out == {8'h00, $past(instant_power_out[1])} && reg_rdata_valid_out)
        else $error("phase b power readback wrong");
    a_offset_word: assert property (offset_word_out[31:28] == 4'h0 // [R3]
        && offset_word_out[27:24] == {4{offset_word_out[23]}})
        else $error("offset word not sign extended");

    // Sequencing engine
    rms_power_pkg::engine_state_t state;
    rms_power_pkg::engine_state_t next_state;
    logic [23:0]        cap [rms_power_pkg::NUM_RMS_CH];
    logic [23:0]        next_cap [rms_power_pkg::NUM_RMS_CH];
    logic signed [47:0] ms [rms_power_pkg::NUM_RMS_CH];
    logic signed [47:0] next_ms [rms_power_pkg::NUM_RMS_CH];
    logic signed [47:0] pw1 [3];
    logic signed [47:0] pw2 [3];
    logic signed [47:0] next_pw1 [3];
    logic signed [47:0] next_pw2 [3];
    logic [3:0]         ch;
    logic [3:0]         next_ch;
    logic [4:0]         step;
    logic [4:0]         next_step;
    logic [1:0]         ph;
    logic [1:0]         next_ph;
    logic [47:0]        rad;
    logic [47:0]        next_rad;
    logic [23:0]        root;
    logic [23:0]        next_root;
    rms_power_pkg::rms_words_t   next_rms;
    rms_power_pkg::phase_words_t next_power;
    logic                        next_update;
    logic signed [47:0] sq;
    logic signed [47:0] ms_new;
    logic signed [47:0] comp;
    logic signed [47:0] prod;
    logic signed [47:0] pin;
    logic signed [47:0] pout;
    logic [23:0]        trial;
    logic [23:0]        raw [rms_power_pkg::NUM_RMS_CH];
    logic [23:0]        vb_raw;
    logic [23:0]        fvb_raw;

    // Phase B synthesis uses raw samples, gain applied after
    always_comb
    begin
        vb_raw  = samples_in.volt[1];
        fvb_raw = samples_in.fund_volt[1];
        if (connection_select == rms_power_pkg::CONNECTION_SELECT_DELTA3)
        begin
            vb_raw  = samples_in.volt[0] - samples_in.volt[2]; // [R12]
            fvb_raw = samples_in.fund_volt[0] - samples_in.fund_volt[2]; // [R12]
        end
        else if (connection_select == rms_power_pkg::CONNECTION_SELECT_DELTA4)
        begin
            vb_raw  = -samples_in.volt[0]; // [R14]
            fvb_raw = -samples_in.fund_volt[0]; // [R14]
        end
    end

    generate
        for (genvar k = 0; k < 3; k++)
        begin : g_phase
            logic [23:0] v_sel;
            logic [23:0] f_sel;
            assign v_sel = (k == 1) ? vb_raw : samples_in.volt[k];
            assign f_sel = (k == 1) ? fvb_raw : samples_in.fund_volt[k];
            assign raw[rms_power_pkg::CH_VA + k]  = apply_gain(v_sel, voltage_gain_in[k]); // [R13]
            assign raw[rms_power_pkg::CH_FVA + k] = apply_gain(f_sel, voltage_gain_in[k]); // [R13]
            assign raw[rms_power_pkg::CH_FIA + k] = samples_in.fund_curr[k];
        end
        for (genvar k = 0; k < 4; k++)
        begin : g_curr
            assign raw[rms_power_pkg::CH_IA + k] = samples_in.curr[k];
        end
    endgenerate
    assign raw[rms_power_pkg::CH_VN] = samples_in.volt[3];

    always_comb
    begin
        next_state  = state;
        next_cap    = cap;
        next_ms     = ms;
        next_pw1    = pw1;
        next_pw2    = pw2;
        next_ch     = ch;
        next_step   = step;
        next_ph     = ph;
        next_rad    = rad;
        next_root   = root;
        next_rms    = rms_word_out;
        next_power  = instant_power_out;
        next_update = 1'b0;
        sq     = $signed(cap[ch]) * $signed(cap[ch]);
        ms_new = ms[ch] + ((sq - ms[ch]) >>> rms_power_pkg::RMS_LPF_SHIFT); // [R6] [R7]
        comp   = ms_new + (sx48(rms_offset_in[ch]) <<< rms_power_pkg::RMS_OS_SHIFT); // [R1] [R2]
        trial  = root | (24'h00_0001 << step);
        prod   = $signed(cap[rms_power_pkg::CH_VA + 32'(ph)])
               * $signed(cap[rms_power_pkg::CH_IA + 32'(ph)]); // [R16] [R15]
        pin    = prod >>> rms_power_pkg::POWER_NORM_SHIFT; // [R19]
        pout   = 48'sd0;
        case (state)
            rms_power_pkg::S_IDLE:
            begin
                if (tick)
                begin
                    next_cap   = raw;
                    next_ch    = 4'h0;
                    next_state = rms_power_pkg::S_SQUARE;
                end
            end
            rms_power_pkg::S_SQUARE:
            begin
                next_ms[ch] = ms_new;
                next_rad    = comp[47] ? 48'h0000_0000_0000 : comp; // [R23]
                next_root   = 24'h00_0000;
                next_step   = 5'(rms_power_pkg::SQRT_STEPS - 1);
                next_state  = rms_power_pkg::S_SQRT;
            end
            rms_power_pkg::S_SQRT:
            begin
                // Bit-serial root keeps to one multiplier at the cost of 24 cycles
                if (48'(trial) * 48'(trial) <= rad)
                    next_root = trial;
                if (step == 5'h00)
                    next_state = rms_power_pkg::S_STORE;
                else
                    next_step = step - 1'b1;
            end
            rms_power_pkg::S_STORE:
            begin
                // No further scaling: full-scale sine maps straight to its rms code
                next_rms[ch] = {8'h00, (root > rms_power_pkg::RMS_MAX) ? rms_power_pkg::RMS_MAX : root}; // [R8] [R5]
                if (ch == 4'(rms_power_pkg::NUM_RMS_CH - 1))
                begin
                    next_ph    = 2'd0;
                    next_state = rms_power_pkg::S_POWER;
                end
                else
                begin
                    next_ch    = ch + 1'b1;
                    next_state = rms_power_pkg::S_SQUARE;
                end
            end
            rms_power_pkg::S_POWER:
            begin
                next_pw1[ph] = pw1[ph] + ((pin - pw1[ph]) >>> rms_power_pkg::POWER_LPF_SHIFT);
                next_pw2[ph] = pw2[ph] + ((pw1[ph] - pw2[ph]) >>> rms_power_pkg::POWER_LPF_SHIFT);
                // Second pole roughly doubles settling and deepens ripple rejection
                pout = power_filter_strength ? next_pw2[ph] : next_pw1[ph]; // [R17]
                if (ph == 2'd1 && connection_select == rms_power_pkg::CONNECTION_SELECT_DELTA3)
                begin
                    next_pw1[ph] = 48'sd0; // [R11]
                    next_pw2[ph] = 48'sd0; // [R11]
                    pout         = 48'sd0; // [R11]
                end
                next_power[ph] = pout[rms_power_pkg::POWER_STORE_SHIFT +: 24]; // [R19] [R18]
                if (ph == 2'd2)
                begin
                    next_update = 1'b1; // [R4] [R21] [R22]
                    next_state  = rms_power_pkg::S_IDLE;
                end
                else
                    next_ph = ph + 1'b1;
            end
            default: next_state = rms_power_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            state             <= rms_power_pkg::S_IDLE;
            cap               <= '{default: 24'h00_0000};
            ms                <= '{default: 48'sd0};
            pw1               <= '{default: 48'sd0};
            pw2               <= '{default: 48'sd0};
            ch                <= 4'h0;
            step              <= 5'h00;
            ph                <= 2'd0;
            rad               <= 48'h0000_0000_0000;
            root              <= 24'h00_0000;
            rms_word_out      <= '0;
            instant_power_out <= '0;
            rms_update_out    <= 1'b0;
        end
        else
        begin
            state             <= next_state;
            cap               <= next_cap;
            ms                <= next_ms;
            pw1               <= next_pw1;
            pw2               <= next_pw2;
            ch                <= next_ch;
            step              <= next_step;
            ph                <= next_ph;
            rad               <= next_rad;
            root              <= next_root;
            rms_word_out      <= next_rms;
            instant_power_out <= next_power;
            rms_update_out    <= next_update;
        end
    end

    sequence s_capture(logic [1:0] mode);
        state == rms_power_pkg::S_IDLE && tick && connection_select == mode;
    endsequence

    sequence s_neg_square;
        state == rms_power_pkg::S_SQUARE && comp[47];
    endsequence

    a_engine_done: assert property (tick |-> state == rms_power_pkg::S_IDLE) // [R22]
        else $error("engine still busy at sample tick");
    a_delta3_synth: assert property (s_capture(rms_power_pkg::CONNECTION_SELECT_DELTA3) // [R12]
        |=> cap[rms_power_pkg::CH_VB] == apply_gain($past(samples_in.volt[0]) - $past(samples_in.volt[2]),
                                                   $past(voltage_gain_in[1])))
        else $error("delta3 phase b voltage wrong");
    a_delta4_synth: assert property (s_capture(rms_power_pkg::CONNECTION_SELECT_DELTA4) // [R14]
        |=> cap[rms_power_pkg::CH_VB] == apply_gain(-$past(samples_in.volt[0]),
                                                   $past(voltage_gain_in[1])))
        else $error("delta4 phase b voltage wrong");
    a_clamp_zero: assert property (s_neg_square // [R23]
        |-> ##25 (state == rms_power_pkg::S_STORE && root == 24'h00_0000))
        else $error("negative square not clamped");
    a_b_power_zero: assert property ((state == rms_power_pkg::S_POWER && ph == 2'd1 // [R11]
        && connection_select == rms_power_pkg::CONNECTION_SELECT_DELTA3) |=> instant_power_out[1] == 24'h00_0000)
        else $error("phase b power not zero in delta3");
    a_rms_pad: assert property (rms_update_out |-> rms_word_out[rms_power_pkg::CH_VB][31:24] == 8'h00 // [R8]
        && rms_word_out[rms_power_pkg::CH_FVC][31:24] == 8'h00 && !rms_word_out[rms_power_pkg::CH_VA][23])
        else $error("rms word padding wrong");
    a_update_rate: assert property ((state == rms_power_pkg::S_IDLE && tick) // [R4]
        |-> ##[368:368] rms_update_out)
        else $error("rms update not within sample period");
endmodule

//--- tb/adc_front_end.sv
module adc_front_end (
    input  wire logic                    clk_in,
    input  wire logic                    unsensed_in,
    input  wire logic [23:0]             va_in,
    input  wire logic [23:0]             vc_in,
    input  wire logic [23:0]             amp_in,
    output rms_power_pkg::samples_t      samples_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] noise = 24'h5A_5A5A;
    initial samples_out = '0;
    always @(posedge clk_in)
    begin
        noise <= ~noise;
        samples_out <= '0;
        samples_out.volt[0] <= va_in;
        samples_out.volt[2] <= vc_in;
        samples_out.fund_volt[0] <= va_in;
        samples_out.fund_volt[2] <= vc_in;
        samples_out.curr[0] <= amp_in;
        samples_out.curr[1] <= amp_in;
        // Unsensed phase B input floats, so never a settled value
        samples_out.volt[1] <= unsensed_in ? noise : 24'h00_0000;
        samples_out.fund_volt[1] <= unsensed_in ? ~noise : 24'h00_0000;
    end
endmodule

//--- tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SC = 450;
    logic                        clk_in = 1'b0;
    logic                        reset_n_in = 1'b0;
    rms_power_pkg::samples_t     samples;
    rms_power_pkg::rms_offsets_t offs = '0;
    rms_power_pkg::phase_words_t gain = '0;
    rms_power_pkg::rms_words_t   rms;
    rms_power_pkg::phase_words_t pwr;
    logic [15:0]                 addr = 16'h0000;
    logic                        wr = 1'b0;
    logic                        rd = 1'b0;
    logic [31:0]                 wdata = 32'h0000_0000;
    logic [3:0]                  osel = 4'h0;
    logic [31:0]                 rdata;
    logic [31:0]                 oword;
    logic                        rvalid;
    logic                        upd;
    logic                        uns = 1'b0;
    logic [23:0]                 va = 24'h00_0000;
    logic [23:0]                 vc = 24'h00_0000;
    logic [23:0]                 amp = 24'h00_0000;
    int                          failures = 0;
    int                          checks = 0;

    always #5 clk_in = ~clk_in;

    adc_front_end fe (.clk_in(clk_in), .unsensed_in(uns), .va_in(va), .vc_in(vc), .amp_in(amp), .samples_out(samples));

    rms_power_datapath #(.SAMPLE_CYCLES(SC)) uut (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .samples_in(samples), .rms_offset_in(offs),
        .voltage_gain_in(gain), .reg_addr_in(addr), .reg_write_in(wr), .reg_read_in(rd),
        .reg_wdata_in(wdata), .offset_sel_in(osel), .reg_rdata_out(rdata), .reg_rdata_valid_out(rvalid),
        .offset_word_out(oword), .rms_word_out(rms), .instant_power_out(pwr), .rms_update_out(upd));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        $display("failures=%0d checks=%0d", failures, checks);
        if (failures == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask

    // Valid lands one edge after the read edge, looked at just after it
    task automatic reg_rd(input logic [15:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1;
        check({31'h0, rvalid}, 32'h1);
        check(rdata, exp);
    endtask

    task automatic wait_upd(output int n);
        n = 0;
        do
        begin
            @(posedge clk_in);
            #1;
            n++;
        end
        while (upd !== 1'b1 && n < 2 * SC);
        if (n >= 2 * SC)
        begin
            failures++;
            finish_test();
        end
    endtask

    // Integer root of the compensated mean square, negative clamps to zero
    function automatic int isqrt(input longint v);
        int r;
        r = 0;
        if (v <= 0)
            return 0;
        while (longint'(r + 1) * longint'(r + 1) <= v)
            r++;
        return r;
    endfunction

    initial
    begin
        int n;
        int m;
        int os[14];
        logic [23:0] p2;
        void'($urandom(42965));
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        reg_rd(rms_power_pkg::ADDR_CONFIG, {16'h0000, rms_power_pkg::CONFIG_RESET});
        reg_rd(rms_power_pkg::ADDR_ACCUMULATION_MODE_CONTROL, {24'h00_0000, rms_power_pkg::ACCUMULATION_MODE_CONTROL_RESET});
        reg_rd(16'h1234, 32'h0000_0000);
        reg_wr(rms_power_pkg::ADDR_CONFIG, 32'h0000_0020);
        reg_rd(rms_power_pkg::ADDR_CONFIG, 32'h0000_0020);
        reg_wr(rms_power_pkg::ADDR_POWER_A, 32'h00AB_CDEF);
        reg_rd(rms_power_pkg::ADDR_POWER_A, 32'h0000_0000);
        // Offsets of form 2*m*m make the root exact, no rounding question
        @(posedge clk_in);
        for (int ch = 0; ch < 14; ch++)
        begin
            m = $urandom_range(2000, 1);
            os[ch] = ($urandom % 4 == 0) ? -2 * m * m : 2 * m * m;
            offs[ch] <= os[ch][23:0];
        end
        for (int i = 0; i < 16; i++)
        begin
            @(posedge clk_in);
            osel <= i[3:0];
            @(posedge clk_in);
            #1;
            check(oword, (i < 14) ? {4'h0, {4{offs[i][23]}}, offs[i]} : 32'h0000_0000);
        end
        wait_upd(n);
        wait_upd(n);
        check(n, SC);
        for (int ch = 0; ch < 14; ch++)
            check(rms[ch], {8'h00, 24'(isqrt(128 * longint'(os[ch])))});
        offs <= '0;
        reg_wr(rms_power_pkg::ADDR_ACCUMULATION_MODE_CONTROL, 32'h0000_0030);
        @(posedge clk_in);
        uns <= 1'b1;
        va <= 24'h20_0000;
        amp <= 24'h10_0000;
        repeat (20) wait_upd(n);
        check(rms[rms_power_pkg::CH_VB], rms[rms_power_pkg::CH_VA]);
        check({pwr[0][23], pwr[1][23], 30'h0}, 32'h4000_0000);
        check({31'h0, pwr[0] == 24'h00_0000}, 32'h0);
        reg_wr(rms_power_pkg::ADDR_ACCUMULATION_MODE_CONTROL, 32'h0000_0010);
        vc <= 24'h40_0000;
        repeat (5) wait_upd(n);
        check(rms[rms_power_pkg::CH_VB], rms[rms_power_pkg::CH_VA]);
        check(rms[rms_power_pkg::CH_FVB], rms[rms_power_pkg::CH_FVA]);
        check({8'h00, pwr[1]}, 32'h0000_0000);
        reg_rd(rms_power_pkg::ADDR_POWER_B, 32'h0000_0000);
        p2 = pwr[0];
        reg_wr(rms_power_pkg::ADDR_CONFIG, 32'h0000_0000);
        wait_upd(n);
        wait_upd(n);
        check({31'h0, pwr[0] > p2}, 32'h1);
        @(posedge clk_in);
        gain[1] <= 24'h40_0000;
        repeat (5) wait_upd(n);
        check({31'h0, rms[rms_power_pkg::CH_VB] > rms[rms_power_pkg::CH_VA]}, 32'h1);
        finish_test();
    end

    initial
    begin
        #900_000;
        failures++;
        finish_test();
    end
endmodule
